// *** rtl/hsid_pkg.sv ***
// Purpose: Shared constants for the haptic status and identity register bank
// Assumes: One clock, synchronous active-high reset, 8-bit registers
// Notes:   Offsets are the byte addresses of the serial register port
package hsid_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PART_IDENTITY  = 8'h00;
    localparam logic [7:0] ADDR_FAULT_STATUS   = 8'h01;
    localparam logic [7:0] ADDR_INTERRUPT_MASK = 8'h02;

    // Late configuration block, index 0 is the lowest offset
    localparam int         CFG_N = 9;
    localparam logic [CFG_N-1:0][7:0] CFG_ADDR = {
        8'h30, 8'h2F, 8'h2E, 8'h2C, 8'h2A, 8'h29, 8'h28, 8'h27, 8'h26};
    localparam logic [CFG_N-1:0][7:0] CFG_RST = {
        8'h00, 8'hC6, 8'h00, 8'h00, 8'h02, 8'h0C, 8'h11, 8'h10, 8'h00};
    localparam int         CFG_IDX_CLAMP2 = 0;
    localparam int         CFG_IDX_OLP_HI = 6;
    localparam int         CFG_IDX_OLP_LO = 7;
    localparam int         CFG_IDX_CURK   = 8;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         ID_PART_LSB     = 4;
    localparam int         FLT_DIAG_BIT    = 7;
    localparam int         FLT_RSV_LSB     = 4;
    localparam int         FLT_DONE_BIT    = 3;
    localparam int         FLT_UV_BIT      = 2;
    localparam int         FLT_OT_BIT      = 1;
    localparam int         FLT_OC_BIT      = 0;
    localparam int         FLAG_N          = 5;
    localparam logic [2:0] FLT_RSV_RST     = 3'h0;
    localparam logic [7:0] MASK_RST        = 8'h18;
    localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

    // ------------------------------------------------------------------
    // Mode encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_DIAG       = 2'h1;
    localparam logic [1:0] MODE_CAL        = 2'h2;
    localparam logic [1:0] PIN_MODE_INT    = 2'h2;

endpackage

// *** rtl/hsid_regs.sv ***
// Purpose: Identity, sticky fault status, interrupt mask and late
//          configuration registers of a haptic actuator driver
// Assumes: Register port decoded by the serial front end on sys_clk;
//          all status events are synchronous to sys_clk
// Notes:   Read data is registered and valid one cycle after rd_en
`timescale 1ns/1ns
module hsid_regs #(
    // Arbitrary identification values
    parameter logic [3:0] PART_CODE     = 4'hA,
    parameter logic [3:0] REVISION_CODE = 4'h7
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data_q,
    output logic            rd_valid_q,
    input  wire logic [1:0] op_mode,
    input  wire logic [1:0] pin_func,
    input  wire logic       actuator_fault,
    input  wire logic       cal_fail,
    input  wire logic       seq_done,
    input  wire logic       diag_done,
    input  wire logic       cal_done,
    input  wire logic [2:0] supply_level,
    input  wire logic [2:0] undervoltage_threshold,
    input  wire logic       over_temp,
    input  wire logic       oc_pos,
    input  wire logic       oc_neg,
    output logic            trigger_interrupt_pin_n_q,
    output logic            trigger_interrupt_pin_oe_q,
    output logic      [7:0] clamp_level_two_q,
    output logic      [9:0] open_loop_period_q,
    output logic      [7:0] current_constant_q
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                          rd_data;
        logic                                rd_valid;
        logic [7:0]                          mask;
        logic [2:0]                          flt_rsv;
        logic [hsid_pkg::CFG_N-1:0][7:0]     cfg;
        logic                                int_n;
        logic                                int_oe;
    } hsid_state_t;

    hsid_state_t                 st_q;
    hsid_state_t                 st_d;
    logic [hsid_pkg::FLAG_N-1:0] set_vec;
    logic [hsid_pkg::FLAG_N-1:0] flag_q;
    logic                        clr_rd;
    logic [7:0]                  fault_view;
    logic                        pin_int;

    // ------------------------------------------------------------------
    // Status events
    // ------------------------------------------------------------------
    // Flag vector order: 0 overcurrent, 1 thermal, 2 undervoltage,
    // 3 completion, 4 diagnostic fail
    always_comb begin
        set_vec    = '0;
        set_vec[0] = oc_pos | oc_neg;
        set_vec[1] = over_temp;
        set_vec[2] = supply_level < undervoltage_threshold;
        set_vec[3] = seq_done | diag_done | cal_done;
        set_vec[4] = ((op_mode == hsid_pkg::MODE_DIAG) & actuator_fault)
                   | ((op_mode == hsid_pkg::MODE_CAL) & cal_fail);
    end

    assign clr_rd = rd_en & (addr == hsid_pkg::ADDR_FAULT_STATUS);

    hsid_sticky hsid_sticky_i (
        .sys_clk (sys_clk),
        .rst     (rst),
        .set     (set_vec),
        .clr     (clr_rd),
        .flag_q  (flag_q)
    );

    always_comb begin
        fault_view = '0;
        fault_view[hsid_pkg::FLT_DIAG_BIT] = flag_q[4];
        fault_view[hsid_pkg::FLT_RSV_LSB +: 3] = st_q.flt_rsv;
        fault_view[hsid_pkg::FLT_DONE_BIT] = flag_q[3];
        fault_view[hsid_pkg::FLT_UV_BIT]   = flag_q[2];
        fault_view[hsid_pkg::FLT_OT_BIT]   = flag_q[1];
        fault_view[hsid_pkg::FLT_OC_BIT]   = flag_q[0];
    end

    assign pin_int = pin_func == hsid_pkg::PIN_MODE_INT;

    // ------------------------------------------------------------------
    // Register access and interrupt pin
    // ------------------------------------------------------------------
    always_comb begin
        st_d          = st_q;
        st_d.rd_valid = rd_en;
        if (rd_en) begin
            st_d.rd_data = hsid_pkg::UNMAPPED_DATA;
            unique case (addr)
                hsid_pkg::ADDR_PART_IDENTITY: begin
                    st_d.rd_data = {PART_CODE, REVISION_CODE};
                end
                hsid_pkg::ADDR_FAULT_STATUS: begin
                    st_d.rd_data = fault_view;
                end
                hsid_pkg::ADDR_INTERRUPT_MASK: begin
                    st_d.rd_data = st_q.mask;
                end
                default: begin
                    for (int i = 0; i < hsid_pkg::CFG_N; i++) begin
                        if (addr == hsid_pkg::CFG_ADDR[i]) begin
                            st_d.rd_data = st_q.cfg[i];
                        end
                    end
                end
            endcase
        end
        if (wr_en) begin
            // Identity and status flags are read only; a status write stores only the reserved bits
            if (addr == hsid_pkg::ADDR_FAULT_STATUS) begin
                st_d.flt_rsv = wr_data[hsid_pkg::FLT_RSV_LSB +: 3];
            end
            if (addr == hsid_pkg::ADDR_INTERRUPT_MASK) begin
                st_d.mask = wr_data;
            end
            for (int i = 0; i < hsid_pkg::CFG_N; i++) begin
                if (addr == hsid_pkg::CFG_ADDR[i]) begin
                    st_d.cfg[i] = wr_data;
                end
            end
        end
        // Diagnostic fail has no mask bit, so it never drives the pin
        st_d.int_oe = pin_int;
        st_d.int_n  = ~(pin_int & |(flag_q[3:0] & ~st_q.mask[3:0]));
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q.rd_data  <= 8'h00;
            st_q.rd_valid <= 1'b0;
            st_q.mask     <= hsid_pkg::MASK_RST;
            st_q.flt_rsv  <= hsid_pkg::FLT_RSV_RST;
            st_q.cfg      <= hsid_pkg::CFG_RST;
            st_q.int_n    <= 1'b1;
            st_q.int_oe   <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_q                  = st_q.rd_data;
    assign rd_valid_q                 = st_q.rd_valid;
    assign trigger_interrupt_pin_n_q  = st_q.int_n;
    assign trigger_interrupt_pin_oe_q = st_q.int_oe;
    assign clamp_level_two_q          = st_q.cfg[hsid_pkg::CFG_IDX_CLAMP2];
    assign open_loop_period_q         =
        {st_q.cfg[hsid_pkg::CFG_IDX_OLP_HI][1:0],
         st_q.cfg[hsid_pkg::CFG_IDX_OLP_LO]};
    assign current_constant_q         = st_q.cfg[hsid_pkg::CFG_IDX_CURK];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_id_read;
        rd_en && addr == hsid_pkg::ADDR_PART_IDENTITY |=>
            rd_valid_q && rd_data_q == {PART_CODE, REVISION_CODE};
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("identity read returned wrong value");

    property p_diag_set;
        op_mode == hsid_pkg::MODE_DIAG && actuator_fault |=> flag_q[4];
    endproperty
    a_diag_set: assert property (p_diag_set)
        else $error("diagnostic fault did not set flag");

    property p_cal_set_simple;
        op_mode == hsid_pkg::MODE_CAL && cal_fail |=>
            flag_q[4] && fault_view[hsid_pkg::FLT_DIAG_BIT];
    endproperty
    a_cal_set_simple: assert property (p_cal_set_simple)
        else $error("calibration failure did not set flag");

    property p_clear_on_read;
        clr_rd && set_vec == '0 |=> flag_q == '0;
    endproperty
    a_clear_on_read: assert property (p_clear_on_read)
        else $error("status read did not clear flags");

    property p_sticky_hold;
        flag_q[2] && !clr_rd |=> flag_q[2];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("undervoltage flag dropped without a read");

    property p_done_set;
        seq_done || diag_done || cal_done |=> flag_q[3];
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("completion did not set flag");

    property p_uv_set;
        supply_level < undervoltage_threshold |=> flag_q[2];
    endproperty
    a_uv_set: assert property (p_uv_set)
        else $error("undervoltage did not set flag");

    property p_ot_set;
        over_temp |=> flag_q[1];
    endproperty
    a_ot_set: assert property (p_ot_set)
        else $error("over-temperature did not set flag");

    property p_oc_set;
        oc_pos || oc_neg |=> flag_q[0];
    endproperty
    a_oc_set: assert property (p_oc_set)
        else $error("overcurrent did not set flag");

    property p_mask_pin;
        pin_int && (flag_q[3:0] & ~st_q.mask[3:0]) != 4'h0 |=>
            !trigger_interrupt_pin_n_q && trigger_interrupt_pin_oe_q;
    endproperty
    a_mask_pin: assert property (p_mask_pin)
        else $error("unmasked event did not assert interrupt pin");

    property p_pin_idle;
        !pin_int || (flag_q[3:0] & ~st_q.mask[3:0]) == 4'h0 |=>
            trigger_interrupt_pin_n_q;
    endproperty
    a_pin_idle: assert property (p_pin_idle)
        else $error("interrupt pin asserted while masked or not in mode");

    property p_set_wins_clear;
        clr_rd && set_vec != '0 |=> (flag_q & $past(set_vec)) == $past(set_vec);
    endproperty
    a_set_wins_clear: assert property (p_set_wins_clear)
        else $error("event lost during clearing read");

    c_read_clear: cover property (clr_rd && flag_q != '0 ##1 flag_q == '0);
    c_irq_pulse:  cover property (pin_int ##1 !trigger_interrupt_pin_n_q);
    c_set_wins:   cover property (clr_rd && set_vec[1]);
    c_cfg_write:  cover property (wr_en && addr == hsid_pkg::CFG_ADDR[8]);

endmodule // hsid_regs

// *** rtl/hsid_sticky.sv ***
// Purpose: Bank of sticky flags, set by hardware, cleared by a status read
// Assumes: Set and clear come from logic on the same clock
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ns
module hsid_sticky (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic [hsid_pkg::FLAG_N-1:0] set,
    input  wire logic                        clr,
    output logic      [hsid_pkg::FLAG_N-1:0] flag_q
);

    typedef struct packed {
        logic [hsid_pkg::FLAG_N-1:0] flag;
    } hsid_sticky_t;

    hsid_sticky_t st_q;
    hsid_sticky_t st_d;

    always_comb begin
        st_d = st_q;
        for (int i = 0; i < hsid_pkg::FLAG_N; i++) begin
            // A clearing read never drops an event of the same cycle
            st_d.flag[i] = set[i] | (st_q.flag[i] & ~clr);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_q = st_q.flag;

endmodule // hsid_sticky

// *** tb/hsid_host.sv ***
// Purpose: Host model driving the register port of hsid_regs
// Assumes: Each task is entered just after a falling edge of sys_clk
// Notes:   Released lines show the inverse of the last value, not stale data
`timescale 1ns/1ns
module hsid_host (
    input  wire logic       sys_clk,
    output logic      [7:0] addr,
    output logic            wr_en,
    output logic      [7:0] wr_data,
    output logic            rd_en,
    input  wire logic [7:0] rd_data_q,
    input  wire logic       rd_valid_q
);
    initial begin
        addr    = 8'hFF;
        wr_en   = 1'b0;
        wr_data = 8'hFF;
        rd_en   = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr    = a;
        wr_data = d;
        wr_en   = 1'b1;
        @(negedge sys_clk);
        wr_en   = 1'b0;
        addr    = ~a;
        wr_data = ~d;
        // An idle edge keeps back-to-back calls from reassigning a strobe
        @(negedge sys_clk);
    endtask

    // Answer lands at the taking edge, settled at this negedge
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        addr  = a;
        rd_en = 1'b1;
        @(negedge sys_clk);
        rd_en = 1'b0;
        addr  = ~a;
        d     = rd_data_q;
        v     = rd_valid_q;
        @(negedge sys_clk);
    endtask
endmodule // hsid_host

// *** tb/tb_hsid_regs.sv ***
// Purpose: Self-checking bench for the haptic status and identity registers
// Assumes: Inputs change on the falling edge only
// Notes:   Each scenario clears the flags it raises before it returns
`timescale 1ns/1ns
module tb_hsid_regs;
    logic       sys_clk, rst, wr_en, rd_en, rd_valid_q, pin_n, pin_oe;
    logic [7:0] addr, wr_data, rd_data_q, clamp2, curk;
    logic [9:0] olp;
    logic [1:0] op_mode, pin_func;
    logic       act_flt, cal_fail, seq_done, diag_done, cal_done;
    logic       over_temp, oc_pos, oc_neg;
    logic [2:0] supply, uv_thr;
    int         error_cnt, num_checks, cyc;

    hsid_regs hsid_regs_i (.sys_clk(sys_clk), .rst(rst), .addr(addr),
        .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .op_mode(op_mode),
        .pin_func(pin_func), .actuator_fault(act_flt), .cal_fail(cal_fail),
        .seq_done(seq_done), .diag_done(diag_done), .cal_done(cal_done),
        .supply_level(supply), .undervoltage_threshold(uv_thr),
        .over_temp(over_temp), .oc_pos(oc_pos), .oc_neg(oc_neg),
        .trigger_interrupt_pin_n_q(pin_n),
        .trigger_interrupt_pin_oe_q(pin_oe), .clamp_level_two_q(clamp2),
        .open_loop_period_q(olp), .current_constant_q(curk));
    hsid_host hsid_host_i (.sys_clk(sys_clk), .addr(addr), .wr_en(wr_en),
        .wr_data(wr_data), .rd_en(rd_en), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q));

    // ------------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Whole run is well under 1000 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        hsid_host_i.rd(a, d, v);
        chk({7'h0, v}, 8'h01);
        chk(d, exp);
        // Valid stands for one cycle only
        chk({7'h0, rd_valid_q}, 8'h00);
    endtask

    task automatic idle();
        {act_flt, cal_fail, seq_done, diag_done, cal_done} = 5'h00;
        {over_temp, oc_pos, oc_neg} = 3'h0;
        op_mode = 2'h0;
        supply  = 3'h7;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdc(8'h00, 8'hA7);
        rdc(8'h01, 8'h00);
        rdc(8'h02, 8'h18);
        for (int i = 0; i < hsid_pkg::CFG_N; i++) begin
            rdc(hsid_pkg::CFG_ADDR[i], hsid_pkg::CFG_RST[i]);
        end
        chk(olp[7:0], 8'hC6);
        rdc(8'h40, 8'h00);
    endtask

    task automatic t_writes();
        hsid_host_i.wr(8'h00, 8'h55);
        rdc(8'h00, 8'hA7);
        hsid_host_i.wr(8'h01, 8'hFF);
        rdc(8'h01, 8'h70);
        hsid_host_i.wr(8'h01, 8'h00);
        hsid_host_i.wr(8'h26, 8'h5A);
        chk(clamp2, 8'h5A);
        rdc(8'h26, 8'h5A);
    endtask

    // Pulse one event for one cycle, read it once, then see it cleared
    task automatic evt(input int k, input logic [7:0] exp);
        case (k)
            0: oc_pos = 1'b1;
            1: oc_neg = 1'b1;
            2: over_temp = 1'b1;
            3: supply = 3'h2;
            4: seq_done = 1'b1;
            5: diag_done = 1'b1;
            6: cal_done = 1'b1;
            7: {op_mode, act_flt} = {hsid_pkg::MODE_DIAG, 1'b1};
            8: {op_mode, cal_fail} = {hsid_pkg::MODE_CAL, 1'b1};
            9: supply = 3'h3;
            10: {op_mode, cal_fail} = {hsid_pkg::MODE_DIAG, 1'b1};
            default: act_flt = 1'b1;
        endcase
        @(negedge sys_clk);
        idle();
        @(negedge sys_clk);
        rdc(8'h01, exp);
        rdc(8'h01, 8'h00);
    endtask

    task automatic t_events();
        evt(0, 8'h01);
        evt(1, 8'h01);
        evt(2, 8'h02);
        evt(3, 8'h04);
        evt(4, 8'h08);
        evt(5, 8'h08);
        evt(6, 8'h08);
        evt(7, 8'h80);
        evt(8, 8'h80);
        // Supply equal to the threshold is not below it
        evt(9, 8'h00);
        uv_thr = 3'h6;
        evt(9, 8'h04);
        uv_thr = 3'h3;
        evt(10, 8'h00);
        evt(11, 8'h00);
    endtask

    task automatic pin_evt(input int k, input logic [1:0] exp);
        if (k == 0) oc_pos = 1'b1;
        else over_temp = 1'b1;
        @(negedge sys_clk);
        idle();
        @(negedge sys_clk);
        chk({6'h0, pin_oe, pin_n}, {6'h0, exp});
    endtask

    task automatic t_mask();
        pin_func = hsid_pkg::PIN_MODE_INT;
        hsid_host_i.wr(8'h02, 8'h02);
        rdc(8'h02, 8'h02);
        pin_evt(1, 2'b11);
        rdc(8'h01, 8'h02);
        pin_evt(0, 2'b10);
        rdc(8'h01, 8'h01);
        @(negedge sys_clk);
        chk({7'h0, pin_n}, 8'h01);
        pin_func = 2'h0;
        @(negedge sys_clk);
        pin_evt(0, 2'b01);
        rdc(8'h01, 8'h01);
    endtask

    task automatic t_race();
        logic [7:0] d;
        logic       v;
        over_temp = 1'b1;
        // Event stands only at the clearing edge of the read
        fork
            hsid_host_i.rd(8'h01, d, v);
            begin
                @(negedge sys_clk);
                over_temp = 1'b0;
            end
        join
        chk(d, 8'h00);
        rdc(8'h01, 8'h02);
    endtask

    // Mid-run reset brings back the reset values of pin, status, mask and both configuration registers written here
    task automatic t_rerun();
        hsid_host_i.wr(8'h02, 8'h0F);
        hsid_host_i.wr(8'h30, 8'h3C);
        chk(curk, 8'h3C);
        hsid_host_i.wr(8'h2E, 8'hFD);
        chk({6'h0, olp[9:8]}, 8'h01);
        over_temp = 1'b1;
        @(negedge sys_clk);
        over_temp = 1'b0;
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        chk({6'h0, pin_oe, pin_n}, 8'h01);
        rdc(8'h01, 8'h00);
        rdc(8'h02, 8'h18);
        chk(curk, 8'h00);
        chk({6'h0, olp[9:8]}, 8'h00);
    endtask

    initial begin
        rst       = 1'b1;
        pin_func  = 2'h0;
        error_cnt = 0;
        num_checks = 0;
        cyc       = 0;
        uv_thr    = 3'h3;
        idle();
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_writes();
        t_events();
        t_mask();
        t_race();
        t_rerun();
        end_of_test();
    end
endmodule // tb_hsid_regs
